// file: comparator_map.vh
// Notes on behaviour
// R01 - Result is high when the positive input is above the negative input.
// R02 - Result is low when the positive input is below the negative input.
// R03 - Enable clear: pins stay GPIO, comparator off; set: negative pin connected.
// R04 - Source select: 00 2V, 01 3V, 10 4V, 11 external positive pin.
// R05 - Result pin enable drives result onto pin, isolating GPIO; else GPIO.
// R06 - Live result bit 2 follows comparator output without latching.
// R07 - Edge select: 01 rising, 10 falling, 11 either, 00 reserved.
// R08 - Selected edge on the result sets the edge flag.
// R09 - Hardware never clears the edge flag; software writes zero.
// R10 - Enabled, flagged and interrupt-enabled comparator requests its vector; enables bits 5,4.
// R11 - Edge event with interrupt enabled wakes from idle, never from stop.
// R12 - Interrupt request rises in the same cycle the edge is detected.
// R13 - Link mode 00: comparator has no effect on PWM outputs.
// R14 - Link mode 01: linked PWM stopped while edge flag is set.
// R15 - Link mode 10: run on rising result, stop on falling result.
// R16 - Link mode 11: run on falling result, stop on rising result.
// R17 - Six select bits 7..2 of PWM-side config choose gated generators.
// R18 - Comparator result passes a two-stage synchronizer before use.
`ifndef COMPARATOR_MAP_VH
`define COMPARATOR_MAP_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define OFS_CMP0_CONTROL  12'h000
`define OFS_CMP1_CONTROL  12'h004
`define OFS_PWM_LINK      12'h008
`define OFS_P3_ANALOG     12'h00c
`define OFS_P2_ANALOG     12'h010
`define OFS_IRQ_ENABLE2   12'h014
`define OFS_IRQ_FLAGS2    12'h018
`define OFS_PWM_SIDE_CFG  12'h01c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_ENABLE        7
`define BIT_SRC_HI        5
`define BIT_SRC_LO        4
`define BIT_PIN_EN        3
`define BIT_LIVE          2
`define BIT_EDGE_HI       1
`define BIT_EDGE_LO       0
`define BIT_IRQ_EN1       5
`define BIT_IRQ_EN0       4
`define BIT_FLAG1         4
`define BIT_FLAG0         3

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define RST_BYTE          8'h00
`define MASK_CONTROL      8'hbb
`define MASK_LINK         8'h0f
`define MASK_P2           8'hf0
`define MASK_INTERRUPT_ENABLE_SECOND         8'h3e
`define MASK_INTERRUPT_FLAGS_SECOND       8'h07
`define MASK_PWM_SIDE     8'hfc

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define SRC_2V            2'h0
`define SRC_3V            2'h1
`define SRC_4V            2'h2
`define SRC_PIN           2'h3
`define EDGE_RISE         2'h1
`define EDGE_FALL         2'h2
`define EDGE_BOTH         2'h3
`define LINK_NONE         2'h0
`define LINK_FLAG         2'h1
`define LINK_RISE_RUN     2'h2
`define LINK_FALL_RUN     2'h3

`endif

// file: result_sync.v
`timescale 1ns/1ps
`include "comparator_map.vh"

module result_sync
(
    input  wire clock,     // System clock
    input  wire rst_b,     // Async reset, active low
    input  wire clk_en,    // Freezes state while low
    input  wire async_in,  // Raw comparator output
    output wire sync_out,  // Synchronised level
    output wire rise,      // One-cycle rising pulse
    output wire fall       // One-cycle falling pulse
);

    reg meta_reg;
    reg sync_reg;
    reg prev_reg;

    // Only sync_reg reads the first stage
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            meta_reg <= async_in;  // see R18
            sync_reg <= meta_reg;  // see R18
            prev_reg <= sync_reg;
        end
    end

    assign sync_out = sync_reg;
    assign rise     = clk_en & sync_reg & ~prev_reg;
    assign fall     = clk_en & ~sync_reg & prev_reg;

endmodule

// file: pwm_gate.v
`timescale 1ns/1ps
`include "comparator_map.vh"

module pwm_gate
(
    input  wire       clock,      // System clock
    input  wire       rst_b,      // Async reset, active low
    input  wire       clk_en,     // Freezes state while low
    input  wire [1:0] link_mode,  // PWM link mode
    input  wire       flag,       // Edge flag of this comparator
    input  wire       rise,       // Synchronised rising pulse
    input  wire       fall,       // Synchronised falling pulse
    output wire       stop        // Stop request for linked PWMs
);

    reg run_reg;

    // In link modes 10 and 11 run state only changes on edges; modes 00 and 01 force it to run
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            run_reg <= 1'b1;
        else if (clk_en)
        begin
            if (link_mode == `LINK_RISE_RUN)
            begin
                if (rise)
                    run_reg <= 1'b1;  // see R15
                else if (fall)
                    run_reg <= 1'b0;  // see R15
            end
            else if (link_mode == `LINK_FALL_RUN)
            begin
                if (fall)
                    run_reg <= 1'b1;  // see R16
                else if (rise)
                    run_reg <= 1'b0;  // see R16
            end
            else
                run_reg <= 1'b1;
        end
    end

    assign stop = (link_mode == `LINK_NONE) ? 1'b0 :  // see R13
                  (link_mode == `LINK_FLAG) ? flag :  // see R14
                  ~run_reg;

endmodule

// file: dual_comparator_control.v
`timescale 1ns/1ps
`include "comparator_map.vh"

module dual_comparator_control
(
    input  wire        clock,           // System clock, 40 MHz
    input  wire        rst_b,           // Async reset, active low
    input  wire        clk_en,          // Freezes state while low
    input  wire        hsel,            // AHB slave select
    input  wire [11:0] haddr,           // AHB address
    input  wire [1:0]  htrans,          // AHB transfer type
    input  wire        hwrite,          // AHB write
    input  wire [2:0]  hsize,           // AHB size
    input  wire [31:0] hwdata,          // AHB write data
    input  wire        hready,          // AHB ready in
    output reg  [31:0] hrdata,          // AHB read data
    output wire        hreadyout,       // AHB ready out
    output wire        hresp,           // AHB response, always OKAY
    input  wire [1:0]  analog_result,   // Raw comparator outputs
    input  wire        idle_mode,       // System is in idle mode
    input  wire        stop_mode,       // System is in stop mode
    output wire [1:0]  comparator_on,   // Analog core enables
    output wire [3:0]  positive_source, // Source select, 2 bits each
    output wire [1:0]  input_pins_cmp,  // Input pins owned by comparator
    output wire [1:0]  result_pin_out,  // Result pin level
    output wire [1:0]  result_pin_oe_b, // Result pin enable, low drives
    output wire [1:0]  cmp_irq,         // Interrupt requests
    output wire        wake_up,         // Idle wake-up request
    output wire [2:0]  pwm_stop,        // Stop gate per PWM generator
    output wire [7:0]  p3_analog,       // Port 3 analog config
    output wire [7:0]  p2_analog        // Port 2 analog config
);

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    reg [7:0]  ctl0_reg;
    reg [7:0]  ctl1_reg;
    reg [7:0]  link_reg;
    reg [7:0]  p3_reg;
    reg [7:0]  p2_reg;
    reg [7:0]  interrupt_enable_second_reg;
    reg [7:0]  interrupt_flags_second_reg;
    reg [7:0]  side_reg;
    reg [1:0]  flag_reg;
    reg        wr_pend_reg;
    reg [11:0] wr_addr_reg;

    wire       take = hsel & htrans[1] & hready;
    wire [7:0] wb   = hwdata[7:0];

    // Zero-wait slave: every transfer completes in its data phase
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ----------------------------------------------------------------
    // Comparator result paths
    // ----------------------------------------------------------------
    wire [1:0] sync_res;
    wire [1:0] rise;
    wire [1:0] fall;
    wire [1:0] stop_req;
    wire [1:0] enable;
    wire [1:0] edge_hit;
    wire [1:0] set_flag;
    wire [1:0] edge_code [0:1];

    assign enable       = {ctl1_reg[`BIT_ENABLE], ctl0_reg[`BIT_ENABLE]};
    assign edge_code[0] = ctl0_reg[`BIT_EDGE_HI:`BIT_EDGE_LO];
    assign edge_code[1] = ctl1_reg[`BIT_EDGE_HI:`BIT_EDGE_LO];

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : per_cmp
            // Disabled core reads as low so no spurious edges appear
            result_sync u_sync
            (
                .clock    (clock),
                .rst_b    (rst_b),
                .clk_en   (clk_en),
                .async_in (analog_result[g] & enable[g]),  // see R03
                .sync_out (sync_res[g]),
                .rise     (rise[g]),
                .fall     (fall[g])
            );

            pwm_gate u_gate
            (
                .clock     (clock),
                .rst_b     (rst_b),
                .clk_en    (clk_en),
                .link_mode (link_reg[2*g+1:2*g]),
                .flag      (flag_reg[g]),
                .rise      (rise[g]),
                .fall      (fall[g]),
                .stop      (stop_req[g])
            );

            // Code 00 is reserved and triggers nothing
            assign edge_hit[g] = (edge_code[g] == `EDGE_RISE) ? rise[g] :         // see R07
                                 (edge_code[g] == `EDGE_FALL) ? fall[g] :         // see R07
                                 (edge_code[g] == `EDGE_BOTH) ? (rise[g] | fall[g]) :
                                 1'b0;
            assign set_flag[g] = enable[g] & edge_hit[g];  // see R08
        end
    endgenerate

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    wire wr_now = wr_pend_reg & clk_en;
    wire wr_fl  = wr_now & (wr_addr_reg == `OFS_IRQ_FLAGS2);
    wire [1:0] sw_flag = {wb[`BIT_FLAG1], wb[`BIT_FLAG0]};

    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl0_reg    <= `RST_BYTE;
            ctl1_reg    <= `RST_BYTE;
            link_reg    <= `RST_BYTE;
            p3_reg      <= `RST_BYTE;
            p2_reg      <= `RST_BYTE;
            interrupt_enable_second_reg    <= `RST_BYTE;
            interrupt_flags_second_reg  <= `RST_BYTE;
            side_reg    <= `RST_BYTE;
            flag_reg    <= 2'h0;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
        end
        else if (clk_en)
        begin
            wr_pend_reg <= take & hwrite;
            if (take)
                wr_addr_reg <= haddr;
            if (wr_now)
            begin
                case (wr_addr_reg)
                    `OFS_CMP0_CONTROL: ctl0_reg   <= wb & `MASK_CONTROL;
                    `OFS_CMP1_CONTROL: ctl1_reg   <= wb & `MASK_CONTROL;
                    `OFS_PWM_LINK:     link_reg   <= wb & `MASK_LINK;
                    `OFS_P3_ANALOG:    p3_reg     <= wb;
                    `OFS_P2_ANALOG:    p2_reg     <= wb & `MASK_P2;
                    `OFS_IRQ_ENABLE2:  interrupt_enable_second_reg   <= wb & `MASK_INTERRUPT_ENABLE_SECOND;
                    `OFS_IRQ_FLAGS2:   interrupt_flags_second_reg <= wb & `MASK_INTERRUPT_FLAGS_SECOND;
                    `OFS_PWM_SIDE_CFG: side_reg   <= wb & `MASK_PWM_SIDE;
                    default:           interrupt_flags_second_reg <= interrupt_flags_second_reg;
                endcase
            end
            // Only software zeroes a flag, and a set in the same cycle wins
            flag_reg <= set_flag | (wr_fl ? (flag_reg & sw_flag) : flag_reg);  // see R09
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    reg [11:0] rd_addr_reg;
    reg [7:0]  rd_byte;

    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            rd_addr_reg <= 12'h000;
        else if (clk_en)
        begin
            if (take)
                rd_addr_reg <= haddr;
        end
    end

    // Decode the address phase itself, so the word stands for the whole data phase
    wire [11:0] rd_sel = take ? haddr : rd_addr_reg;

    // Live bit is sampled as it stands, never held in a shadow copy
    always @*
    begin
        rd_byte = 8'h00;
        case (rd_sel)
            `OFS_CMP0_CONTROL:
            begin
                rd_byte            = ctl0_reg;
                rd_byte[`BIT_LIVE] = sync_res[0];  // see R06
            end
            `OFS_CMP1_CONTROL:
            begin
                rd_byte            = ctl1_reg;
                rd_byte[`BIT_LIVE] = sync_res[1];  // see R06
            end
            `OFS_PWM_LINK:     rd_byte = link_reg;
            `OFS_P3_ANALOG:    rd_byte = p3_reg;
            `OFS_P2_ANALOG:    rd_byte = p2_reg;
            `OFS_IRQ_ENABLE2:  rd_byte = interrupt_enable_second_reg;
            `OFS_IRQ_FLAGS2:
            begin
                rd_byte             = interrupt_flags_second_reg;
                rd_byte[`BIT_FLAG1] = flag_reg[1];
                rd_byte[`BIT_FLAG0] = flag_reg[0];
            end
            `OFS_PWM_SIDE_CFG: rd_byte = side_reg;
            default:           rd_byte = 8'h00;
        endcase
    end

    // Data output stays registered: read data is loaded at the address phase
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            hrdata <= 32'h00000000;
        else if (clk_en)
            hrdata <= {24'h000000, rd_byte};
    end

    // ----------------------------------------------------------------
    // Interrupt, wake-up and pin control
    // ----------------------------------------------------------------
    wire [1:0] irq_en = {interrupt_enable_second_reg[`BIT_IRQ_EN1], interrupt_enable_second_reg[`BIT_IRQ_EN0]};

    // Request includes the setting pulse, so it rises with the detection
    assign cmp_irq = enable & irq_en & (flag_reg | set_flag);  // see R10, see R12

    // Stop mode is masked here: an edge seen in stop mode still sets the flag but never wakes
    assign wake_up = idle_mode & ~stop_mode & |(enable & irq_en & set_flag);  // see R11

    assign comparator_on   = enable;  // see R01, see R02
    assign input_pins_cmp  = enable;  // see R03
    assign positive_source = {ctl1_reg[`BIT_SRC_HI:`BIT_SRC_LO],
                              ctl0_reg[`BIT_SRC_HI:`BIT_SRC_LO]};  // see R04

    wire [1:0] pin_en = enable & {ctl1_reg[`BIT_PIN_EN], ctl0_reg[`BIT_PIN_EN]};
    assign result_pin_out  = sync_res & pin_en;  // see R05
    assign result_pin_oe_b = ~pin_en;            // see R05

    // Bits 7..2 pair by generator: {gen3 c1,gen3 c0,gen2 c1,gen2 c0,gen1 c1,gen1 c0}
    genvar p;
    generate
        for (p = 0; p < 3; p = p + 1)
        begin : per_pwm
            assign pwm_stop[p] = (side_reg[2*p+2] & stop_req[0]) |
                                 (side_reg[2*p+3] & stop_req[1]);  // see R17
        end
    endgenerate

    assign p3_analog = p3_reg;
    assign p2_analog = p2_reg;

endmodule

// file: dcc_checker.sv
`timescale 1ns/1ps

module dcc_checker
(
    input wire logic        clock,           // System clock
    input wire logic        rst_b,           // Reset, active low
    input wire logic        hsel,            // Slave select
    input wire logic [1:0]  htrans,          // Transfer type
    input wire logic        hwrite,          // Write
    input wire logic        hready,          // Ready in
    input wire logic        hreadyout,       // Ready out
    input wire logic        hresp,           // Response
    input wire logic [1:0]  analog_result,   // Raw results
    input wire logic        idle_mode,       // Idle
    input wire logic        stop_mode,       // Stop
    input wire logic [1:0]  comparator_on,   // Core enables
    input wire logic [1:0]  input_pins_cmp,  // Input pin owner
    input wire logic [1:0]  result_pin_out,  // Pin level
    input wire logic [1:0]  result_pin_oe_b, // Pin enable, low drives
    input wire logic [1:0]  cmp_irq,         // Requests
    input wire logic        wake_up          // Wake pulse
);
    // ----------------------------------------------------------------
    // Port relations
    // ----------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    // A taken write lands two edges after its address phase
    wire wr_req = hsel && htrans[1] && hwrite && hready;

    sequence s_pin_on;
        !result_pin_oe_b[0] [*3];
    endsequence

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait OKAY");
    a_input_pins: assert property (input_pins_cmp == comparator_on)
        else $error("input pins not owned by enabled core");
    a_pin_drive: assert property (!result_pin_oe_b[0] |-> comparator_on[0])
        else $error("result pin driven while core disabled");
    a_pin_isolate: assert property (result_pin_oe_b[1] |-> !result_pin_out[1])
        else $error("result level present on released pin");
    a_live_sync: assert property (s_pin_on |-> result_pin_out[0] == $past(analog_result[0], 2))
        else $error("pin level not two-stage synchronised result");
    a_irq_enabled: assert property (cmp_irq[1] |-> comparator_on[1])
        else $error("request from disabled comparator");
    a_flag_sticky: assert property ($fell(cmp_irq[1]) |-> $past(wr_req, 2))
        else $error("request dropped without software write");
    a_wake_idle: assert property (wake_up |-> idle_mode && !stop_mode && cmp_irq != 2'h0)
        else $error("wake outside idle or without request");
    a_irq_detect: assert property ($rose(cmp_irq[1]) && !$past(wr_req)
        && !$past(wr_req, 2) |-> ($past(analog_result[1], 2) && $past(comparator_on[1], 2))
            != ($past(analog_result[1], 3) && $past(comparator_on[1], 3)))
        else $error("request not in the edge detect cycle");
endmodule

bind dual_comparator_control dcc_checker u_chk (.clock, .rst_b, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .analog_result, .idle_mode, .stop_mode, .comparator_on,
    .input_pins_cmp, .result_pin_out, .result_pin_oe_b, .cmp_irq, .wake_up);

// file: analog_side_model.sv
`timescale 1ns/1ps

module analog_side_model
(
    input  wire logic        clock,           // System clock
    input  wire logic [1:0]  comparator_on,   // Core enables
    input  wire logic [3:0]  positive_source, // Source codes
    input  wire logic [15:0] pin_mv,          // Positive pin, mV
    input  wire logic [31:0] neg_mv,          // Negative pins, mV
    input  wire logic [2:0]  pwm_stop,        // Gate requests
    output logic      [1:0]  analog_result,   // Core outputs
    output logic      [2:0]  pwm_running      // Generator state
);
    // ----------------------------------------------------------------
    // Cores
    // ----------------------------------------------------------------
    logic        toggle_reg = 1'b0;
    logic [15:0] pos_mv [0:1];

    // A core that is off has no stable level; toggling exposes missing gating
    always @(posedge clock)
        toggle_reg <= ~toggle_reg;

    always_comb
    begin
        for (int n = 0; n < 2; n++)
        begin
            case (positive_source[n*2 +: 2])
                2'h0: pos_mv[n] = 16'h07d0;
                2'h1: pos_mv[n] = 16'h0bb8;
                2'h2: pos_mv[n] = 16'h0fa0;
                default: pos_mv[n] = pin_mv;
            endcase
            analog_result[n] = comparator_on[n] ? (pos_mv[n] > neg_mv[n*16 +: 16])
                                                : toggle_reg;
        end
    end

    assign pwm_running = ~pwm_stop;
endmodule

// file: testbench.sv
`timescale 1ns/1ps
`include "comparator_map.vh"

module testbench;
    logic        clock, rst_b, hsel, hwrite, idle_mode, stop_mode;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata, neg_mv, rd;
    logic [15:0] pin_mv;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, wake_up;
    wire  [1:0]  analog_result, comparator_on, input_pins_cmp, result_pin_out;
    wire  [1:0]  result_pin_oe_b, cmp_irq;
    wire  [3:0]  positive_source;
    wire  [2:0]  pwm_stop, pwm_running;
    wire  [7:0]  p3_analog, p2_analog;
    int          fails, n_tests;

    dual_comparator_control u_dut (.clock, .rst_b, .clk_en(1'b1), .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .analog_result, .idle_mode, .stop_mode, .comparator_on, .positive_source,
        .input_pins_cmp, .result_pin_out, .result_pin_oe_b, .cmp_irq, .wake_up, .pwm_stop,
        .p3_analog, .p2_analog);

    analog_side_model u_model (.clock, .comparator_on, .positive_source, .pin_mv, .neg_mv,
        .pwm_stop, .analog_result, .pwm_running);

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Against the 3 V source: 2.5 V on the negative pin gives a high result
    task level(input int n, input logic hi);
        @(posedge clock);
        neg_mv[n*16 +: 16] <= hi ? 16'h09c4 : 16'h0dac;
        repeat (5) @(posedge clock);
    endtask

    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task t_regs;
        logic [7:0] m [0:7];
        m = '{`MASK_CONTROL, `MASK_CONTROL, `MASK_LINK, 8'hff, `MASK_P2, `MASK_INTERRUPT_ENABLE_SECOND,
              `MASK_INTERRUPT_FLAGS_SECOND, `MASK_PWM_SIDE};
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b0, 12'(i * 4), 32'h0);
            chk("reset value", 32'h0, rd);
            bus(1'b1, 12'(i * 4), 32'hffffffff);
            bus(1'b0, 12'(i * 4), 32'h0);
            chk("writable bits", 32'(m[i]), rd);
            if (i == 4)
                chk("p2 pins", 32'(`MASK_P2), 32'(p2_analog));
            bus(1'b1, 12'(i * 4), 32'h0);
        end
        bus(1'b1, `OFS_P3_ANALOG, 32'h5a);
        bus(1'b0, `OFS_PWM_LINK, 32'h0);
        chk("link after p3", 32'h0, rd);
        bus(1'b0, `OFS_P3_ANALOG, 32'h0);
        chk("p3 readback", 32'h5a, rd);
        chk("p3 pins", 32'h5a, 32'(p3_analog));
        bus(1'b1, 12'h020, 32'hffffffff);
        bus(1'b0, 12'h020, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("t_regs done");
    endtask

    task t_sources;
        logic e;
        pin_mv <= 16'h1388;
        level(0, 1'b1);
        for (int s = 0; s < 4; s++)
        begin
            e = (s != 0);
            bus(1'b1, `OFS_CMP0_CONTROL, 32'h88 | (s << 4));
            repeat (4) @(posedge clock);
            bus(1'b0, `OFS_CMP0_CONTROL, 32'h0);
            chk("live", 32'(e), 32'(rd[2]));
            chk("source", 32'(s), 32'(positive_source[1:0]));
            chk("pin", 32'(e), 32'(result_pin_out[0]));
            chk("pin oe", 32'h0, 32'(result_pin_oe_b[0]));
            chk("input pins", 32'h1, 32'(input_pins_cmp[0]));
        end
        bus(1'b1, `OFS_CMP0_CONTROL, 32'h0);
        #1 chk("off", 32'h3, 32'(result_pin_oe_b));
        $display("t_sources done");
    endtask

    task t_edges;
        bus(1'b1, `OFS_IRQ_ENABLE2, 32'h20);
        for (int g = 0; g < 4; g++)
        begin
            bus(1'b1, `OFS_CMP1_CONTROL, 32'h90 | g);
            for (int r = 1; r >= 0; r--)
            begin
                bus(1'b1, `OFS_IRQ_FLAGS2, 32'h0);
                #1 chk("irq clear", 32'h0, 32'(cmp_irq[1]));
                level(1, r[0]);
                bus(1'b0, `OFS_IRQ_FLAGS2, 32'h0);
                chk("edge flag", 32'(g[1 - r]), 32'(rd[4]));
                chk("irq", 32'(g[1 - r]), 32'(cmp_irq[1]));
            end
        end
        bus(1'b1, `OFS_IRQ_FLAGS2, 32'h0);
        $display("t_edges done");
    endtask

    task t_wake;
        logic w;
        idle_mode <= 1'b1;
        @(posedge clock);
        neg_mv[31:16] <= 16'h09c4;
        @(posedge clock);
        #1 chk("irq early", 32'h0, 32'(cmp_irq[1]));
        @(posedge clock);
        #1 chk("irq detect", 32'h1, 32'(cmp_irq[1]));
        chk("wake", 32'h1, 32'(wake_up));
        bus(1'b1, `OFS_IRQ_FLAGS2, 32'h0);
        stop_mode <= 1'b1;
        neg_mv[31:16] <= 16'h0dac;
        w = 1'b0;
        repeat (6) @(posedge clock) #1 w |= wake_up;
        chk("stop wake", 32'h0, 32'(w));
        @(posedge clock);
        idle_mode <= 1'b0;
        stop_mode <= 1'b0;
        bus(1'b1, `OFS_IRQ_FLAGS2, 32'h0);
        $display("t_wake done");
    endtask

    task t_pwm;
        logic [3:0] er, ef;
        er = 4'b1010;
        ef = 4'b0110;
        // Generator 1 follows comparator 0, generator 3 follows the idle comparator 1
        bus(1'b1, `OFS_PWM_SIDE_CFG, 32'h84);
        level(0, 1'b0);
        bus(1'b1, `OFS_CMP0_CONTROL, 32'h93);
        for (int md = 0; md < 4; md++)
        begin
            bus(1'b1, `OFS_PWM_LINK, 32'(md));
            bus(1'b1, `OFS_IRQ_FLAGS2, 32'h0);
            level(0, 1'b1);
            chk("stop rise", 32'(er[md]), 32'(pwm_stop));
            chk("irq0 masked", 32'h0, 32'(cmp_irq[0]));
            level(0, 1'b0);
            chk("stop fall", 32'(ef[md]), 32'(pwm_stop));
            if (md == 1)
            begin
                bus(1'b1, `OFS_IRQ_FLAGS2, 32'h0);
                #1 chk("stop clear", 32'h0, 32'(pwm_stop));
            end
        end
        $display("t_pwm done");
    endtask

    // ----------------------------------------------------------------
    // Run
    // ----------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial
    begin
        repeat (5000) @(posedge clock);
        fails++;
        $display("MISMATCH watchdog expected done seen hang");
        wrap_up;
    end

    initial
    begin
        {rst_b, hsel, hwrite, idle_mode, stop_mode} = 5'h0;
        haddr = 12'h000;
        htrans = 2'h0;
        hwdata = 32'h0;
        pin_mv = 16'h0000;
        neg_mv = {16'h0dac, 16'h0dac};
        fails = 0;
        n_tests = 0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        t_regs;
        t_sources;
        t_edges;
        t_wake;
        t_pwm;
        wrap_up;
    end
endmodule
